// ===== design/sadc_dev.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_dev #(
  parameter int unsigned STEP_CYC = sadc_pkg::CONV_STEP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  sadc_if.dev link,
  input wire logic signed [sadc_pkg::AIN_BITS-1:0] ain_i,
  output logic [sadc_pkg::ADDR_BITS-1:0] chan_o,
  output logic sampling_o,
  output logic busy_o,
  output logic [sadc_pkg::RES_BITS-1:0] result_o
);
  import sadc_pkg::*;

  if (STEP_CYC < 1 || STEP_CYC > 255) begin : g_chk
    $error("STEP_CYC must lie in 1..255.");
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_SHIFT = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_LOST = 5'b10000
  } sadc_st_t;

  sadc_st_t state_r;
  sadc_st_t state_nxt;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic cs_fall;
  logic cs_rise;
  logic clk_rise;
  logic clk_fall;
  logic [1:0] sys_cnt_r;
  logic sys_fall;
  logic [7:0] set_cnt_r;
  logic [1:0] edge_cnt_r;
  logic settled;
  logic start_xfer;
  logic [4:0] rise_cnt_r;
  logic [4:0] fall_cnt_r;
  sadc_addr_t addr_sh_r;
  sadc_addr_t chan_r;
  logic sampling_r;
  sadc_code_t sh_r;
  logic oe_n_r;
  logic eoc_r;
  logic conv_busy_r;
  logic conv_start;
  logic conv_done;
  logic abort;
  logic [3:0] bit_r;
  logic [7:0] step_r;
  sadc_code_t sar_r;
  sadc_code_t trial;
  sadc_code_t result_r;
  logic signed [AIN_BITS-1:0] hold_r;
  logic signed [AIN_BITS-1:0] pick;

  // Select, serial clock and address are asynchronous pins.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 3'b100;
      sync2_r <= 3'b100;
      sync3_r <= 3'b100;
    end else begin
      sync1_r <= {link.cs_n, link.sclk, link.addr};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign cs_fall = sync3_r[2] & ~sync2_r[2];
  assign cs_rise = ~sync3_r[2] & sync2_r[2];
  assign clk_rise = ~sync3_r[1] & sync2_r[1];
  assign clk_fall = sync3_r[1] & ~sync2_r[1];

  // Internal system clock used by the select noise filter.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sys_cnt_r <= 2'd0;
    end else begin
      sys_cnt_r <= sys_cnt_r + 2'd1;
    end
  end

  assign sys_fall = (sys_cnt_r == 2'(SYS_DIV_CYC - 1));
  assign settled = (set_cnt_r == 8'd0) && (edge_cnt_r == 2'(SYS_EDGES));
  assign abort = cs_fall & conv_busy_r; // [RULE2]
  assign conv_done = conv_busy_r & ~abort & (step_r == 8'd0) & (bit_r == 4'd0);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = ST_SETTLE; // [RULE1] [RULE14]
        end
      end
      ST_SETTLE: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end else if (settled) begin
          state_nxt = ST_SHIFT; // [RULE5]
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE; // [RULE13]
        end else if (conv_done && rise_cnt_r < 5'(XFER_MIN)) begin
          state_nxt = ST_LOST; // [RULE12]
        end else if (clk_fall && fall_cnt_r == 5'(XFER_MAX - 1)) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end else if (!conv_busy_r) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_LOST: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE; // [RULE12]
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign start_xfer = (state_nxt == ST_SHIFT) && (state_r != ST_SHIFT);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settle counter restarts on every select fall, so an abort settles again.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      set_cnt_r <= 8'd0;
      edge_cnt_r <= 2'd0;
    end else if (state_r != ST_SETTLE) begin
      set_cnt_r <= 8'(CS_SETUP_CYC - 1); // [RULE5] [RULE14]
      edge_cnt_r <= 2'd0;
    end else if (set_cnt_r != 8'd0) begin
      set_cnt_r <= set_cnt_r - 8'd1;
    end else if (sys_fall && edge_cnt_r != 2'(SYS_EDGES)) begin
      edge_cnt_r <= edge_cnt_r + 2'd1; // [RULE5]
    end
  end

  // Serial clock edges are counted only while the transfer is open.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_cnt_r <= 5'd0;
      fall_cnt_r <= 5'd0;
    end else if (start_xfer) begin
      rise_cnt_r <= 5'd0;
      fall_cnt_r <= 5'd0;
    end else if (state_r == ST_SHIFT) begin
      if (clk_rise && rise_cnt_r != 5'd31) begin
        rise_cnt_r <= rise_cnt_r + 5'd1;
      end
      if (clk_fall && fall_cnt_r != 5'd31) begin
        fall_cnt_r <= fall_cnt_r + 5'd1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_sh_r <= '0;
      chan_r <= '0;
    end else if (state_r == ST_SHIFT && clk_rise && rise_cnt_r < 5'(ADDR_BITS)) begin
      addr_sh_r <= {addr_sh_r[ADDR_BITS-2:0], sync2_r[0]}; // [RULE10]
      if (rise_cnt_r == 5'(ADDR_BITS - 1)) begin
        chan_r <= {addr_sh_r[ADDR_BITS-2:0], sync2_r[0]}; // [RULE10]
      end
    end
  end

  always_comb begin
    if (chan_r == ADDR_TEST_MID) begin
      pick = $signed({2'b00, CODE_MID});
    end else if (chan_r == ADDR_TEST_LO) begin
      pick = $signed({2'b00, CODE_LO});
    end else if (chan_r == ADDR_TEST_HI) begin
      pick = $signed({2'b00, CODE_HI});
    end else begin
      pick = ain_i;
    end
  end

  assign conv_start = (state_r == ST_SHIFT) && clk_fall && fall_cnt_r == 5'(HOLD_FALL - 1);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sampling_r <= 1'b0;
      hold_r <= '0;
    end else if (state_r != ST_SHIFT) begin
      sampling_r <= 1'b0;
    end else if (clk_fall && fall_cnt_r == 5'(SAMPLE_FALL - 1)) begin
      sampling_r <= 1'b1; // [RULE11]
    end else if (conv_start) begin
      sampling_r <= 1'b0; // [RULE11]
      hold_r <= pick;
    end
  end

  assign trial = sar_r | (sadc_code_t'(1) << bit_r);

  // One bit per step, from the top weight down.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_busy_r <= 1'b0;
      bit_r <= 4'd0;
      step_r <= 8'd0;
      sar_r <= '0;
    end else if (abort) begin
      conv_busy_r <= 1'b0; // [RULE2]
    end else if (conv_start) begin
      conv_busy_r <= 1'b1;
      bit_r <= 4'(RES_BITS - 1); // [RULE9]
      step_r <= 8'(STEP_CYC - 1);
      sar_r <= '0;
    end else if (conv_busy_r) begin
      if (step_r != 8'd0) begin
        step_r <= step_r - 8'd1;
      end else begin
        step_r <= 8'(STEP_CYC - 1);
        if ($signed({2'b00, trial}) <= hold_r) begin
          sar_r <= trial; // [RULE4] [RULE9]
        end
        if (bit_r == 4'd0) begin
          conv_busy_r <= 1'b0;
        end else begin
          bit_r <= bit_r - 4'd1; // [RULE9]
        end
      end
    end
  end

  // Result register changes only on a finished conversion.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_r <= RESULT_RST;
      eoc_r <= 1'b1;
    end else if (abort) begin
      eoc_r <= 1'b1; // [RULE2]
    end else if (conv_start) begin
      eoc_r <= 1'b0;
    end else if (conv_done) begin
      result_r <= ($signed({2'b00, trial}) <= hold_r) ? trial : sar_r; // [RULE9]
      eoc_r <= 1'b1;
    end
  end

  // Previous result leaves MSB first, one bit per serial clock fall.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_r <= '0;
    end else if ((state_r == ST_IDLE && cs_fall) || start_xfer) begin
      sh_r <= result_r; // [RULE2]
    end else if (state_r == ST_SHIFT && clk_fall) begin
      sh_r <= {sh_r[RES_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= (state_nxt == ST_IDLE); // [RULE13]
    end
  end

  assign link.dout = sh_r[RES_BITS-1];
  assign link.dout_oe_n = oe_n_r;
  assign link.eoc = eoc_r;
  assign chan_o = chan_r;
  assign sampling_o = sampling_r;
  assign busy_o = conv_busy_r;
  assign result_o = result_r;
endmodule
`default_nettype wire

// ===== design/sadc_pkg.sv
// What this block does
// [RULE1] Select falling edge starts every sequence; code also restarts one after the 16th fall once conversion ends.
// [RULE2] Select fall mid-cycle aborts; result kept.
// [RULE3] Host avoids select fall near conversion end.
// [RULE4] Over-range gives all ones, under gives zeros.
// [RULE5] Ignore inputs for setup plus two ticks.
// [RULE6] Host waits 1.425 us before first address.
// [RULE7] Rising edge within 9.5 us after tenth fall.
// [RULE8] Serial clock from static up to 2.1 MHz.
// [RULE9] Result resolved MSB first down to LSB.
// [RULE10] Four address bits, MSB first, first rises.
// [RULE11] Sample from fourth fall, hold at tenth.
// [RULE12] Late eleventh rise loses sync until reselect.
// [RULE13] Select high floats data, ignores clock, address.
// [RULE14] After abort, settle again before address.
package sadc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 20_000;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned AIN_BITS = RES_BITS + 2;
  localparam int unsigned ADDR_BITS = 4;
  localparam int unsigned XFER_MIN = 11;
  localparam int unsigned XFER_MAX = 16;
  localparam int unsigned SAMPLE_FALL = 4;
  localparam int unsigned HOLD_FALL = 10;
  localparam int unsigned CS_SETUP_PS = 1_425_000;
  localparam int unsigned CS_SETUP_CYC = (CS_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYS_DIV_CYC = 4;
  localparam int unsigned SYS_EDGES = 2;
  localparam int unsigned HOST_SETUP_CYC = CS_SETUP_CYC + SYS_EDGES * SYS_DIV_CYC + 8;
  localparam int unsigned SCLK_MAX_KHZ = 2_100;
  localparam int unsigned SCLK_HALF_CYC =
    (CLK_HZ / 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int unsigned EDGE_GAP_PS = 9_500_000;
  localparam int unsigned EDGE_GAP_CYC = EDGE_GAP_PS / CLK_PERIOD_PS;
  localparam int unsigned CONV_STEP_CYC = 100;
  localparam logic [3:0] ADDR_TEST_MID = 4'hb;
  localparam logic [3:0] ADDR_TEST_LO = 4'hc;
  localparam logic [3:0] ADDR_TEST_HI = 4'hd;
  localparam logic [9:0] CODE_MID = 10'h200;
  localparam logic [9:0] CODE_LO = 10'h000;
  localparam logic [9:0] CODE_HI = 10'h3ff;
  localparam logic [9:0] RESULT_RST = 10'h000;
  typedef logic [RES_BITS-1:0] sadc_code_t;
  typedef logic [ADDR_BITS-1:0] sadc_addr_t;
endpackage

// ===== design/sadc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sadc_if;
  logic cs_n;
  logic sclk;
  logic addr;
  logic dout;
  logic dout_oe_n;
  logic eoc;
  wire dout_line;
  // A released line shows the inverse of the last bit, so a stray sample stands out.
  assign dout_line = dout_oe_n ? ~dout : dout;
  modport dev (input cs_n, input sclk, input addr, output dout, output dout_oe_n, output eoc);
  modport host (output cs_n, output sclk, output addr, input dout_line, input eoc);
endinterface
`default_nettype wire

// ===== design/sadc_host.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_host #(
  parameter int unsigned HALF_CYC = sadc_pkg::SCLK_HALF_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  sadc_if.host link,
  input wire logic start_i,
  input wire logic [sadc_pkg::ADDR_BITS-1:0] chan_i,
  input wire logic [4:0] nbits_i,
  output logic ready_o,
  output logic done_o,
  output logic [sadc_pkg::RES_BITS-1:0] data_o
);
  import sadc_pkg::*;

  if (HALF_CYC < SCLK_HALF_CYC || HALF_CYC > 200 || 2 * HALF_CYC > EDGE_GAP_CYC)
  begin : g_chk
    $error("HALF_CYC outside the serial clock limits.");
  end

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_WAIT = 5'b00010,
    HS_SETUP = 5'b00100,
    HS_CLK = 5'b01000,
    HS_END = 5'b10000
  } sadc_hst_t;

  sadc_hst_t state_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [7:0] cnt_r;
  logic [4:0] nbits_r;
  logic [4:0] edges_r;
  sadc_addr_t addr_sh_r;
  sadc_code_t data_sh_r;
  sadc_code_t data_r;
  logic cs_n_r;
  logic sclk_r;
  logic addr_r;
  logic done_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 2'b00;
      sync2_r <= 2'b00;
    end else begin
      sync1_r <= {link.eoc, link.dout_line};
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= HS_IDLE;
      cnt_r <= 8'd0;
      nbits_r <= 5'(XFER_MIN);
      edges_r <= 5'd0;
      addr_sh_r <= '0;
      data_sh_r <= '0;
      data_r <= '0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      addr_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        HS_IDLE: begin
          if (start_i) begin
            addr_sh_r <= chan_i;
            if (nbits_i < 5'(XFER_MIN)) begin
              nbits_r <= 5'(XFER_MIN);
            end else if (nbits_i > 5'(XFER_MAX)) begin
              nbits_r <= 5'(XFER_MAX);
            end else begin
              nbits_r <= nbits_i;
            end
            state_r <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (sync2_r[1]) begin
            cs_n_r <= 1'b0; // [RULE1] [RULE3]
            addr_r <= addr_sh_r[ADDR_BITS-1]; // [RULE10]
            addr_sh_r <= {addr_sh_r[ADDR_BITS-2:0], 1'b0};
            cnt_r <= 8'(HOST_SETUP_CYC - 1);
            state_r <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (cnt_r != 8'd0) begin
            cnt_r <= cnt_r - 8'd1; // [RULE6]
          end else begin
            edges_r <= 5'd0;
            cnt_r <= 8'(HALF_CYC - 1);
            state_r <= HS_CLK;
          end
        end
        HS_CLK: begin
          if (cnt_r != 8'd0) begin
            cnt_r <= cnt_r - 8'd1;
          end else begin
            cnt_r <= 8'(HALF_CYC - 1); // [RULE7] [RULE8]
            sclk_r <= ~sclk_r;
            if (!sclk_r) begin
              edges_r <= edges_r + 5'd1;
              if (edges_r < 5'(RES_BITS)) begin
                data_sh_r <= {data_sh_r[RES_BITS-2:0], sync2_r[0]}; // [RULE9]
              end
            end else if (edges_r == nbits_r) begin
              state_r <= HS_END;
            end else begin
              addr_r <= addr_sh_r[ADDR_BITS-1]; // [RULE10]
              addr_sh_r <= {addr_sh_r[ADDR_BITS-2:0], 1'b0};
            end
          end
        end
        HS_END: begin
          cs_n_r <= 1'b1;
          addr_r <= 1'b0;
          data_r <= data_sh_r;
          done_r <= 1'b1;
          state_r <= HS_IDLE;
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.addr = addr_r;
  assign ready_o = (state_r == HS_IDLE);
  assign done_o = done_r;
  assign data_o = data_r;
endmodule
`default_nettype wire

// ===== test/sadc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_properties #(
  parameter int unsigned STEP_CYC = sadc_pkg::CONV_STEP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic addr,
  input wire logic dout_oe_n,
  input wire logic eoc
);
  import sadc_pkg::*;
  localparam int CONV_LO = 10 * STEP_CYC - 12;
  localparam int CONV_HI = 10 * STEP_CYC + 6;
  localparam int SETTLE = CS_SETUP_CYC + SYS_EDGES * SYS_DIV_CYC;
  localparam int GAP = EDGE_GAP_CYC;
  logic sclk_r;
  logic [7:0] sel_cnt_r;
  logic [3:0] fall_cnt_r;
  logic [11:0] eoc_cnt_r;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_r <= 1'b0;
      sel_cnt_r <= 8'h00;
      fall_cnt_r <= 4'h0;
      eoc_cnt_r <= 12'h000;
    end else begin
      sclk_r <= sclk;
      sel_cnt_r <= cs_n ? 8'h00 : sel_cnt_r + 8'(sel_cnt_r != 8'hff);
      fall_cnt_r <= cs_n ? 4'h0 : fall_cnt_r + 4'(sclk_r && !sclk && fall_cnt_r != 4'hf);
      eoc_cnt_r <= eoc ? 12'h000 : eoc_cnt_r + 12'h001;
    end
  end
  sequence tenth_fall_s;
    sclk_r && !sclk && (fall_cnt_r == 4'h9);
  endsequence
  sel_drive_a: assert property ($fell(cs_n) |-> ##[2:6] !dout_oe_n)
    else $error("data output not driven after select fall");
  drive_cause_a: assert property ($fell(dout_oe_n) |-> !cs_n && !$past(cs_n, 2))
    else $error("data output driven without select");
  float_idle_a: assert property (cs_n [*6] |-> dout_oe_n)
    else $error("data output driven while deselected");
  settle_wait_a: assert property ($rose(sclk) |-> sel_cnt_r >= 8'(SETTLE))
    else $error("serial clock before select setup");
  clk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 sclk [*2])
    else $error("serial clock high too short");
  clk_low_a: assert property ($fell(sclk) |-> !sclk [*8] ##1 !sclk [*2])
    else $error("serial clock low too short");
  addr_setup_a: assert property ($changed(addr) && !cs_n |-> !sclk [*5])
    else $error("address changed too close to clock rise");
  eoc_drop_a: assert property (tenth_fall_s |-> ##[2:8] !eoc)
    else $error("end of conversion not low after tenth fall");
  late_gap_a: assert property (tenth_fall_s |-> ##[1:GAP] $rose(sclk))
    else $error("no clock rise after tenth fall");
  conv_span_a: assert property ($rose(eoc) |-> eoc_cnt_r >= 12'(CONV_LO)
    && eoc_cnt_r <= 12'(CONV_HI))
    else $error("conversion length wrong");
  host_order_a: assert property ($fell(cs_n) |-> eoc && $past(eoc))
    else $error("select fell during conversion");
endmodule
`default_nettype wire

// ===== test/serial_adc_select_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end
module serial_adc_select_control_bench;
  import sadc_pkg::*;
  localparam int unsigned STEP = 10;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic start_i = 1'b0;
  sadc_addr_t chan_i = '0;
  logic [4:0] nbits_i = 5'h0b;
  logic signed [AIN_BITS-1:0] ain_i = '0;
  logic signed [AIN_BITS-1:0] ain2 = '0;
  logic ready_o;
  logic done_o;
  logic samp_o;
  logic busy_o;
  logic samp2;
  logic busy2;
  sadc_code_t data_o;
  sadc_code_t result_o;
  sadc_code_t result2;
  sadc_addr_t chan_o;
  sadc_addr_t chan2;
  int errors = 0;
  int total_checks = 0;
  sadc_code_t exp_q[$];
  sadc_addr_t chan_q[$];
  sadc_code_t prev_code = RESULT_RST;
  sadc_code_t ec;
  sadc_addr_t ea;
  logic [9:0] wire_bits;
  logic [3:0] wire_addr;
  logic [9:0] rd_bits;
  int bit_n = 0;
  int rd_n = 0;
  sadc_if link();
  sadc_if link2();
  sadc_host sadc_host_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(link.host),
    .start_i(start_i), .chan_i(chan_i), .nbits_i(nbits_i), .ready_o(ready_o),
    .done_o(done_o), .data_o(data_o));
  sadc_dev #(.STEP_CYC(STEP)) sadc_dev_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .link(link.dev), .ain_i(ain_i), .chan_o(chan_o), .sampling_o(samp_o), .busy_o(busy_o),
    .result_o(result_o));
  sadc_dev #(.STEP_CYC(STEP)) sadc_dev_inst2 (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .link(link2.dev), .ain_i(ain2), .chan_o(chan2), .sampling_o(samp2), .busy_o(busy2),
    .result_o(result2));
  sadc_properties #(.STEP_CYC(STEP)) sadc_properties_inst (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .cs_n(link.cs_n), .sclk(link.sclk), .addr(link.addr),
    .dout_oe_n(link.dout_oe_n), .eoc(link.eoc));
  always #10 ref_clk_i = ~ref_clk_i;
  always @(negedge link.cs_n) bit_n = 0;
  always @(posedge link.sclk) begin
    if (!link.cs_n && bit_n < 10) wire_bits[9-bit_n] = link.dout_line;
    if (!link.cs_n && bit_n < 4) wire_addr[3-bit_n] = link.addr;
    bit_n++;
  end
  always @(posedge ref_clk_i) begin
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("mismatch queue expected note seen none");
      end else begin
        ec = exp_q.pop_front();
        ea = chan_q.pop_front();
        `CHK("data_o", ec, data_o)
        `CHK("wire_bits", ec, wire_bits)
        `CHK("wire_addr", ea, wire_addr)
        `CHK("chan_o", ea, chan_o)
      end
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input sadc_addr_t ch, input logic signed [AIN_BITS-1:0] a,
    input sadc_code_t code);
    while (ready_o !== 1'b1 || busy_o !== 1'b0) begin
      @(posedge ref_clk_i);
    end
    `CHK("result_o", prev_code, result_o)
    exp_q.push_back(prev_code);
    chan_q.push_back(ch);
    prev_code = code;
    ain_i <= a;
    chan_i <= ch;
    nbits_i <= 5'($urandom_range(11, 16));
    start_i <= 1'b1;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic clk2(input logic a);
    link2.addr <= a;
    repeat (4) @(posedge ref_clk_i);
    link2.sclk <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    if (rd_n < 10) rd_bits[9-rd_n] = link2.dout_line;
    rd_n++;
    link2.sclk <= 1'b0;
  endtask
  task automatic sel2(input sadc_addr_t ad, input int nclk);
    link2.cs_n <= 1'b0;
    clk2(1'b1);
    clk2(1'b1);
    repeat (HOST_SETUP_CYC) @(posedge ref_clk_i);
    rd_n = 0;
    for (int i = 0; i < nclk; i++) begin
      clk2(i < 4 ? ad[3-i] : ~link2.addr);
      if (i == 3) `CHK("samp2", 1'b0, samp2)
      if (i == 4) `CHK("samp2", 1'b1, samp2)
    end
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic idle2(input int cyc);
    link2.cs_n <= 1'b1;
    repeat (cyc) @(posedge ref_clk_i);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    errors++;
    stop_test();
  end
  initial begin
    logic signed [AIN_BITS-1:0] a;
    int n;
    n = $urandom(32'hd2cb);
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.addr = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    xfer(ADDR_TEST_MID, 12'h000, CODE_MID);
    xfer(ADDR_TEST_LO, 12'h1f4, CODE_LO);
    xfer(ADDR_TEST_HI, 12'h000, CODE_HI);
    xfer(4'he, 12'h7ff, 10'h3ff);
    xfer(4'hf, 12'hffb, 10'h000);
    xfer(4'he, 12'h3ff, 10'h3ff);
    xfer(4'hf, 12'h000, 10'h000);
    xfer(4'he, 12'h3fe, 10'h3fe);
    repeat (12) begin
      a = 12'($urandom_range(1, 1022));
      xfer(4'($urandom_range(0, 10)), a, a[9:0]);
    end
    xfer(4'h0, 12'h000, 10'h000);
    sel2(ADDR_TEST_HI, 11);
    idle2(10 * STEP + 20);
    `CHK("rd_bits", RESULT_RST, rd_bits)
    `CHK("chan2", ADDR_TEST_HI, chan2)
    `CHK("result2", CODE_HI, result2)
    `CHK("float", 1'b1, link2.dout_oe_n)
    sel2(ADDR_TEST_LO, 10);
    idle2(8);
    `CHK("busy2", 1'b1, busy2)
    `CHK("eoc2", 1'b0, link2.eoc)
    sel2(ADDR_TEST_MID, 11);
    `CHK("result2", CODE_HI, result2)
    `CHK("rd_bits", CODE_HI, rd_bits)
    idle2(10 * STEP + 20);
    `CHK("result2", CODE_MID, result2)
    `CHK("chan2", ADDR_TEST_MID, chan2)
    sel2(ADDR_TEST_HI, 10);
    repeat (10 * STEP + 20) @(posedge ref_clk_i);
    repeat (6) clk2(1'b1);
    repeat (8) @(posedge ref_clk_i);
    `CHK("lost_dout", 1'b0, link2.dout_line)
    idle2(8);
    sel2(ADDR_TEST_LO, 11);
    idle2(10 * STEP + 20);
    `CHK("rd_bits", CODE_HI, rd_bits)
    `CHK("result2", CODE_LO, result2)
    `CHK("pending", 0, exp_q.size())
    stop_test();
  end
endmodule
`default_nettype wire
